/* File: core/vca_top.sv */
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "vca_cfg.svh"

module vca_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`VCA_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion side
  input wire logic sample_valid,
  input wire vca_pkg::vca_sample_t sample,
  input wire logic refresh_cmd,
  // status
  output logic avg_valid
);

  function automatic logic [15:0] fmt(input logic signed [15:0] raw, input logic [1:0] sel);
    logic [15:0] r;
    r = raw;
    case (sel)
      `VCA_RNG_UNI: r = raw[15] ? 16'h0000 : {raw[14:0], 1'b0};
      `VCA_RNG_HALF: begin
        // half range is a shift of the signed raw value, saturated at the ends
        if (raw[15] != raw[14]) begin
          r = raw[15] ? 16'h8000 : 16'h7FFF;
        end else begin
          r = {raw[14:0], 1'b0};
        end
      end
      default: r = raw;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] avg_len(input logic [2:0] depth);
    return 8'(`VCA_AVG_MIN_LEN << depth);
  endfunction

  function automatic logic [47:0] sext48(input logic signed [31:0] v);
    return {{16{v[31]}}, v};
  endfunction

  // control state
  logic [1:0] acc_src;
  logic [2:0] avg_depth;
  logic bulk_mode;
  vca_pkg::vca_range_t range_config_reg;
  vca_pkg::vca_apb_state_t apb_state;

  // data state
  logic signed [15:0] last_bus;
  logic signed [15:0] last_sense;
  logic [15:0] bus_volt_result;
  logic [15:0] sense_volt_result;
  logic [31:0] power_reg;
  logic [15:0] bus_volt_average;
  logic [15:0] sense_volt_average;
  logic [47:0] accum_value_reg;
  logic signed [15:0] bus_hist [0:`VCA_HIST_WORDS-1];
  logic signed [15:0] sense_hist [0:`VCA_HIST_WORDS-1];
  logic [6:0] wr_ptr;
  logic [7:0] fill_cnt;
  logic signed [23:0] bus_sum;
  logic signed [23:0] sense_sum;

  // apb decode
  logic [`VCA_ADDR_W-1:0] addr;
  logic access_q;
  logic wr_fire;
  logic addr_ok;
  logic avg_addr;
  logic refused;
  logic [31:0] next_rdata;
  logic [2:0] wr_depth;
  logic depth_change;
  logic acc_clr;
  logic refresh_fire;

  assign addr = paddr;
  assign access_q = psel && penable && !pready;
  assign wr_fire = psel && penable && pready && pwrite;
  assign avg_addr = (addr == `VCA_OFF_BUS_AVG) || (addr == `VCA_OFF_SENSE_AVG);
  assign refused = !pwrite && avg_addr && !avg_valid && !bulk_mode;
  assign wr_depth = pwdata[`VCA_CTRL_DEPTH];
  assign depth_change = wr_fire && (addr == `VCA_OFF_CTRL) && (wr_depth <= `VCA_DEPTH_MAX)
    && (wr_depth != avg_depth);
  assign acc_clr = wr_fire && (addr == `VCA_OFF_CTRL) && pwdata[`VCA_CTRL_ACC_CLR];
  assign refresh_fire = refresh_cmd || (wr_fire && (addr == `VCA_OFF_REFRESH));

  always_comb begin
    addr_ok = 1'b1;
    next_rdata = 32'h0000_0000;
    case (addr)
      `VCA_OFF_CTRL: begin
        next_rdata[`VCA_CTRL_SRC] = acc_src;
        next_rdata[`VCA_CTRL_DEPTH] = avg_depth;
        next_rdata[`VCA_CTRL_BULK] = bulk_mode;
      end
      `VCA_OFF_RANGE: begin
        next_rdata[`VCA_RANGE_BUS] = range_config_reg.bus_range_sel;
        next_rdata[`VCA_RANGE_SENSE] = range_config_reg.sense_range_sel;
      end
      `VCA_OFF_BUS_RES: next_rdata[15:0] = bus_volt_result;
      `VCA_OFF_SENSE_RES: next_rdata[15:0] = sense_volt_result;
      `VCA_OFF_POWER: next_rdata = power_reg;
      `VCA_OFF_BUS_AVG: next_rdata[15:0] = bus_volt_average;
      `VCA_OFF_SENSE_AVG: next_rdata[15:0] = sense_volt_average;
      `VCA_OFF_ACC_LO: next_rdata = accum_value_reg[31:0];
      `VCA_OFF_ACC_HI: next_rdata[15:0] = accum_value_reg[47:32];
      `VCA_OFF_STATUS: next_rdata = {23'h000000, avg_valid, fill_cnt};
      `VCA_OFF_REFRESH: next_rdata = 32'h0000_0000;
      default: addr_ok = 1'b0;
    endcase
  end

  // fixed one wait state keeps read data and refusal registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= vca_pkg::VCA_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      case (apb_state)
        vca_pkg::VCA_IDLE: begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          if (access_q) begin
            apb_state <= vca_pkg::VCA_DONE;
            pready <= 1'b1;
            pslverr <= !addr_ok || refused;
            prdata <= (pwrite || refused) ? 32'h0000_0000 : next_rdata;
          end
        end
        vca_pkg::VCA_DONE: begin
          apb_state <= vca_pkg::VCA_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          apb_state <= vca_pkg::VCA_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_src <= `VCA_SRC_POWER;
      avg_depth <= `VCA_DEPTH_RST;
      bulk_mode <= 1'b0;
    end else if (wr_fire && (addr == `VCA_OFF_CTRL)) begin
      acc_src <= pwdata[`VCA_CTRL_SRC];
      bulk_mode <= pwdata[`VCA_CTRL_BULK];
      // reserved depth codes leave the depth alone
      if (wr_depth <= `VCA_DEPTH_MAX) begin
        avg_depth <= wr_depth;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_config_reg <= '0;
    end else if (wr_fire && (addr == `VCA_OFF_RANGE)) begin
      range_config_reg.bus_range_sel <= pwdata[`VCA_RANGE_BUS];
      range_config_reg.sense_range_sel <= pwdata[`VCA_RANGE_SENSE];
    end
  end

  // accumulator and power
  logic signed [31:0] power_now;
  logic signed [31:0] power_last;
  logic [47:0] acc_addend;
  assign power_now = sample.bus * sample.sense;
  assign power_last = last_bus * last_sense;

  always_comb begin
    case (acc_src)
      `VCA_SRC_BUS: acc_addend = sext48(32'(sample.bus));
      `VCA_SRC_SENSE: acc_addend = sext48(32'(sample.sense));
      `VCA_SRC_POWER: acc_addend = sext48(power_now);
      default: acc_addend = 48'h0000_0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_value_reg <= 48'h0000_0000_0000;
    end else if (acc_clr) begin
      accum_value_reg <= 48'h0000_0000_0000;
    end else if (sample_valid) begin
      accum_value_reg <= accum_value_reg + acc_addend;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_bus <= 16'sh0000;
      last_sense <= 16'sh0000;
    end else if (sample_valid) begin
      last_bus <= sample.bus;
      last_sense <= sample.sense;
    end
  end

  // rolling averages over signed raw samples
  logic [7:0] cur_len;
  logic [6:0] old_idx;
  logic [2:0] avg_shift;
  logic signed [15:0] bus_old;
  logic signed [15:0] sense_old;
  logic signed [15:0] bus_avg_now;
  logic signed [15:0] sense_avg_now;
  logic full;
  assign cur_len = avg_len(avg_depth);
  assign old_idx = 7'(wr_ptr - 7'(cur_len));
  assign bus_old = bus_hist[old_idx];
  assign sense_old = sense_hist[old_idx];
  assign full = (fill_cnt == cur_len);
  assign avg_shift = 3'(avg_depth + `VCA_AVG_BASE_SHIFT);
  assign bus_avg_now = 16'(bus_sum >>> avg_shift);
  assign sense_avg_now = 16'(sense_sum >>> avg_shift);

  always_ff @(posedge pclk) begin
    if (sample_valid) begin
      bus_hist[wr_ptr] <= sample.bus;
      sense_hist[wr_ptr] <= sample.sense;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= 7'h00;
      fill_cnt <= 8'h00;
      bus_sum <= 24'sh000000;
      sense_sum <= 24'sh000000;
      avg_valid <= 1'b0;
    end else if (depth_change) begin
      wr_ptr <= 7'h00;
      fill_cnt <= 8'h00;
      bus_sum <= 24'sh000000;
      sense_sum <= 24'sh000000;
      avg_valid <= 1'b0;
    end else if (sample_valid) begin
      wr_ptr <= 7'(wr_ptr + 7'h01);
      if (full) begin
        bus_sum <= bus_sum + 24'(sample.bus) - 24'(bus_old);
        sense_sum <= sense_sum + 24'(sample.sense) - 24'(sense_old);
      end else begin
        bus_sum <= bus_sum + 24'(sample.bus);
        sense_sum <= sense_sum + 24'(sample.sense);
        fill_cnt <= 8'(fill_cnt + 8'h01);
      end
      avg_valid <= full || (8'(fill_cnt + 8'h01) == cur_len);
    end
  end

  // readable copies move only on refresh
  logic [15:0] next_bus_avg;
  assign next_bus_avg = fmt(bus_avg_now, range_config_reg.bus_range_sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_volt_result <= 16'h0000;
      sense_volt_result <= 16'h0000;
      power_reg <= 32'h0000_0000;
      bus_volt_average <= 16'h0000;
      sense_volt_average <= 16'h0000;
    end else if (refresh_fire) begin
      bus_volt_result <= fmt(last_bus, range_config_reg.bus_range_sel);
      sense_volt_result <= fmt(last_sense, range_config_reg.sense_range_sel);
      power_reg <= power_last;
      bus_volt_average <= next_bus_avg;
      sense_volt_average <= fmt(sense_avg_now, range_config_reg.sense_range_sel);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PREADY_WAIT: assert property (access_q |=> pready && $stable(paddr))
    else $error("pready not given one cycle after access");
  AST_NACK_INVALID: assert property (
    access_q && refused |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("invalid average read not refused");
  AST_BULK_NO_NACK: assert property (
    access_q && !pwrite && avg_addr && bulk_mode && addr_ok |=> pready && !pslverr)
    else $error("bulk average read refused");
  AST_DEPTH_CLEAR: assert property (
    depth_change |=> !avg_valid && fill_cnt == 8'h00 && bus_sum == 24'sh000000)
    else $error("depth change did not clear averaging");
  AST_VALID_FILL: assert property (avg_valid |-> fill_cnt == cur_len)
    else $error("averages valid before enough samples");
  AST_DEPTH_LEGAL: assert property (avg_depth <= `VCA_DEPTH_MAX)
    else $error("reserved depth code stored");
  AST_ACC_POWER: assert property (
    sample_valid && !acc_clr && acc_src == `VCA_SRC_POWER
    |=> accum_value_reg == $past(accum_value_reg) + sext48($past(power_now)))
    else $error("power not added to accumulator");
  AST_ACC_BUS: assert property (
    sample_valid && !acc_clr && acc_src == `VCA_SRC_BUS
    |=> accum_value_reg == $past(accum_value_reg) + sext48(32'($past(sample.bus))))
    else $error("bus result not added to accumulator");
  AST_REFRESH_AVG: assert property (refresh_fire |=> bus_volt_average == $past(next_bus_avg))
    else $error("refresh did not copy average");
  AST_AVG_HOLD: assert property (!refresh_fire |=> $stable(bus_volt_average))
    else $error("average register moved without refresh");
  AST_UNI_NEG: assert property (
    refresh_fire && range_config_reg.sense_range_sel == `VCA_RNG_UNI && last_sense[15]
    |=> sense_volt_result == 16'h0000)
    else $error("unipolar negative sense not clamped");

  // accumulator, formatting, copy and averaging checks
  AST_ACC_SENSE: assert property (
    sample_valid && !acc_clr && acc_src == `VCA_SRC_SENSE
    |=> accum_value_reg == $past(accum_value_reg) + sext48(32'($past(sample.sense))))
    else $error("sense result not added to accumulator");
  AST_ACC_IDLE: assert property (
    sample_valid && !acc_clr && acc_src == `VCA_SRC_NONE
    |=> $stable(accum_value_reg))
    else $error("unused source code changed accumulator");
  AST_POWER_COPY: assert property (refresh_fire |=> power_reg == $past(power_last))
    else $error("refresh did not copy power");
  AST_REFRESH_SAVG: assert property (
    refresh_fire |=> sense_volt_average == fmt($past(sense_avg_now),
    $past(range_config_reg.sense_range_sel)))
    else $error("refresh did not copy sense average");
  AST_SAVG_HOLD: assert property (!refresh_fire |=> $stable(sense_volt_average))
    else $error("sense average moved without refresh");
  AST_UNI_BUS_POS: assert property (
    refresh_fire && range_config_reg.bus_range_sel == `VCA_RNG_UNI && !last_bus[15]
    |=> bus_volt_result == {$past(last_bus[14:0]), 1'b0})
    else $error("unipolar bus result not scaled");
  AST_UNI_BUS_NEG: assert property (
    refresh_fire && range_config_reg.bus_range_sel == `VCA_RNG_UNI && last_bus[15]
    |=> bus_volt_result == 16'h0000)
    else $error("unipolar negative bus not clamped");
  AST_BI_BUS: assert property (
    refresh_fire && range_config_reg.bus_range_sel == `VCA_RNG_BI
    |=> bus_volt_result == $past(last_bus))
    else $error("bipolar bus result not raw");
  AST_BI_SENSE: assert property (
    refresh_fire && range_config_reg.sense_range_sel == `VCA_RNG_BI
    |=> sense_volt_result == $past(last_sense))
    else $error("bipolar sense result not raw");
  AST_HALF_BUS: assert property (
    refresh_fire && range_config_reg.bus_range_sel == `VCA_RNG_HALF
    && last_bus[15] == last_bus[14]
    |=> bus_volt_result == {$past(last_bus[14:0]), 1'b0})
    else $error("half range bus result not shifted");
  AST_SUM_STEP: assert property (
    sample_valid && !depth_change && !full
    |=> bus_sum == $past(bus_sum) + 24'($past(sample.bus)))
    else $error("signed sample not summed");
  AST_VALID_RISE: assert property (
    sample_valid && !depth_change && 8'(fill_cnt + 8'h01) == cur_len |=> avg_valid)
    else $error("averages not valid at depth");
  AST_FILL_CAP: assert property (fill_cnt <= cur_len)
    else $error("fill count beyond depth");
  AST_VALID_READ: assert property (
    access_q && !pwrite && avg_addr && avg_valid |=> pready && !pslverr)
    else $error("valid average read refused");

  COV_REFUSED: cover property (access_q && refused);
  COV_VALID: cover property ($rose(avg_valid));
  COV_DEPTH: cover property (depth_change);
  COV_BULK: cover property (access_q && avg_addr && bulk_mode && !avg_valid);
  COV_HALF: cover property (refresh_fire && range_config_reg.bus_range_sel == `VCA_RNG_HALF);

endmodule // vca_top

/* File: core/vca_cfg.svh */
// How it works
// - bus and sense results are 16 bits: unsigned, signed, or signed half range
// - product of raw bus and sense samples feeds the accumulator when power is chosen
// - accumulator source: 10b bus, 01b sense, 00b power
// - accumulator source resets to power
// - bus voltage defaults to unipolar, zero to full scale
// - bipolar bus mode stores two's complement results
// - bus lsb is full scale over 2^16; half range shifts by one
// - sense defaults to unipolar, stored as unsigned 16 bits
// - bipolar sense mode stores two's complement results
// - sense lsb follows 100/200/100 mV spans via the same shift
// - range code 10b picks half range, separately for bus and sense
// - averages roll every conversion, copied to readable registers on refresh
// - averages are taken over signed raw samples
// - averaging depth resets to 001b, eight samples
// - depths of 4 to 128 samples for both inputs
// - averages are valid only once the depth's sample count is collected
// - any depth change clears averaging state and validity
// - single reads of the average registers are refused while invalid
// - bulk reads return averages without refusal
// - half range is a left shift of the signed raw value, saturated at the ends
`ifndef VCA_CFG_SVH
`define VCA_CFG_SVH

`define VCA_ADDR_W 8
`define VCA_OFF_CTRL 8'h00
`define VCA_OFF_RANGE 8'h04
`define VCA_OFF_BUS_RES 8'h08
`define VCA_OFF_SENSE_RES 8'h0C
`define VCA_OFF_POWER 8'h10
`define VCA_OFF_BUS_AVG 8'h14
`define VCA_OFF_SENSE_AVG 8'h18
`define VCA_OFF_ACC_LO 8'h1C
`define VCA_OFF_ACC_HI 8'h20
`define VCA_OFF_STATUS 8'h24
`define VCA_OFF_REFRESH 8'h28

`define VCA_CTRL_SRC 1:0
`define VCA_CTRL_DEPTH 4:2
`define VCA_CTRL_BULK 5
`define VCA_CTRL_ACC_CLR 6
`define VCA_RANGE_BUS 1:0
`define VCA_RANGE_SENSE 3:2

`define VCA_SRC_POWER 2'h0
`define VCA_SRC_SENSE 2'h1
`define VCA_SRC_BUS 2'h2
`define VCA_SRC_NONE 2'h3
`define VCA_RNG_UNI 2'h0
`define VCA_RNG_BI 2'h1
`define VCA_RNG_HALF 2'h2
`define VCA_DEPTH_RST 3'h1
`define VCA_DEPTH_MAX 3'h5
`define VCA_AVG_MIN_LEN 8'h04
`define VCA_AVG_BASE_SHIFT 3'h2
`define VCA_HIST_WORDS 128

`endif

/* File: core/vca_pkg.sv */
package vca_pkg;
  typedef struct packed {
    logic signed [15:0] bus;
    logic signed [15:0] sense;
  } vca_sample_t;

  typedef struct packed {
    logic [1:0] bus_range_sel;
    logic [1:0] sense_range_sel;
  } vca_range_t;

  typedef enum logic [1:0] {VCA_IDLE, VCA_ACCESS, VCA_DONE} vca_apb_state_t;
endpackage

/* File: tb/vca_host_model.sv */
`timescale 1ns/10ps
`include "vca_cfg.svh"

module vca_host_model (
  // apb master side
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [`VCA_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // request stays put until pready; the bound keeps a dead slave from hanging the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output bit to);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    to = (n >= 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // vca_host_model

/* File: tb/tb_voltage_current_result_averager.sv */
`timescale 1ns/10ps
`include "vca_cfg.svh"

module tb_voltage_current_result_averager;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr;
  logic [`VCA_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sample_valid;
  vca_pkg::vca_sample_t sample;
  logic refresh_cmd;
  logic avg_valid;
  int n_errors;
  int samples_checked;
  logic [15:0] bus_e [4] = '{16'h0200, 16'h0100, 16'h0200, 16'h0100};
  logic [15:0] sres_e [4] = '{16'h0000, 16'hFF00, 16'hFE00, 16'hFF00};
  logic [15:0] savg_e [4] = '{16'h0200, 16'h0100, 16'h0200, 16'h0100};
  logic [1:0] src_c [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
  logic [31:0] acc_e [4] = '{32'h0000_0100, 32'hFFFF_FF00, 32'hFFFF_0000, 32'h0000_0000};
  logic [15:0] hi_e [4] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};

  vca_top u_vca_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample(sample),
    .refresh_cmd(refresh_cmd), .avg_valid(avg_valid));

  vca_host_model u_vca_host_model (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // msk zero skips the data: read data of an unmapped access is left open
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk,
                    input logic eerr);
    logic [31:0] d;
    logic e;
    bit to;
    u_vca_host_model.xfer(1'b0, a, 32'h0, d, e, to);
    if (to) begin
      n_errors++;
      $display("MISMATCH %0t no pready", $time);
      print_verdict();
    end else begin
      chk({31'h0, e}, {31'h0, eerr}, "error flag");
      chk(d & msk, exp, "read data");
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bit to;
    u_vca_host_model.xfer(1'b1, a, d, q, e, to);
    if (to) begin
      n_errors++;
      $display("MISMATCH %0t no pready", $time);
      print_verdict();
    end
  endtask

  // back-to-back conversions; trailing edge lets the last one land
  task automatic feed(input int n, input logic [15:0] b, input logic [15:0] s);
    sample_valid <= 1'b1;
    sample <= {b, s};
    repeat (n) @(posedge pclk);
    sample_valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic refresh;
    refresh_cmd <= 1'b1;
    @(posedge pclk);
    refresh_cmd <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    sample_valid = 1'b0;
    sample = '0;
    refresh_cmd = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`VCA_OFF_CTRL, 32'h4, 32'h1F, 1'b0);
    rd(`VCA_OFF_RANGE, 32'h0, 32'hF, 1'b0);
    rd(8'hFC, 32'h0, 32'h0, 1'b1);
    rd(`VCA_OFF_BUS_AVG, 32'h0, 32'hFFFF_FFFF, 1'b1);
    rd(`VCA_OFF_SENSE_AVG, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(`VCA_OFF_CTRL, 32'h24);
    rd(`VCA_OFF_BUS_AVG, 32'h0, 32'hFFFF, 1'b0);
    wr(`VCA_OFF_CTRL, 32'h4);
    feed(7, 16'h0100, 16'hFF00);
    chk({31'h0, avg_valid}, 32'h0, "early valid");
    feed(1, 16'h0100, 16'hFF00);
    chk({31'h0, avg_valid}, 32'h1, "valid");
    rd(`VCA_OFF_BUS_AVG, 32'h0, 32'hFFFF, 1'b0);
    refresh();
    rd(`VCA_OFF_BUS_AVG, 32'h200, 32'hFFFF, 1'b0);
    rd(`VCA_OFF_POWER, 32'hFFFF_0000, 32'hFFFF_FFFF, 1'b0);
    rd(`VCA_OFF_ACC_LO, 32'hFFF8_0000, 32'hFFFF_FFFF, 1'b0);
    // mixed signs: an unsigned average would differ
    feed(4, 16'h0100, 16'h0300);
    feed(4, 16'h0100, 16'hFF00);
    for (int c = 0; c < 4; c++) begin
      // code 1 with depth eight is the near-zero setup a host is advised to use
      wr(`VCA_OFF_RANGE, 32'(c) | (32'(c) << 2));
      // code 3 reads as bipolar; its refresh comes over the register bus
      if (c == 3) begin
        wr(`VCA_OFF_REFRESH, 32'h0);
      end else begin
        refresh();
      end
      rd(`VCA_OFF_BUS_RES, {16'h0, bus_e[c]}, 32'hFFFF, 1'b0);
      rd(`VCA_OFF_SENSE_RES, {16'h0, sres_e[c]}, 32'hFFFF, 1'b0);
      rd(`VCA_OFF_BUS_AVG, {16'h0, bus_e[c]}, 32'hFFFF, 1'b0);
      rd(`VCA_OFF_SENSE_AVG, {16'h0, savg_e[c]}, 32'hFFFF, 1'b0);
    end
    rd(`VCA_OFF_STATUS, 32'h108, 32'h1FF, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(`VCA_OFF_CTRL, 32'h44 | {30'h0, src_c[s]});
      feed(1, 16'h0100, 16'hFF00);
      rd(`VCA_OFF_ACC_LO, acc_e[s], 32'hFFFF_FFFF, 1'b0);
      rd(`VCA_OFF_ACC_HI, {16'h0, hi_e[s]}, 32'hFFFF, 1'b0);
    end
    for (int d = 0; d < 6; d++) begin
      wr(`VCA_OFF_CTRL, 32'(d) << 2);
      @(posedge pclk);
      chk({31'h0, avg_valid}, 32'h0, "valid after depth change");
      feed((4 << d) - 1, 16'h0100, 16'hFF00);
      chk({31'h0, avg_valid}, 32'h0, "valid one short");
      feed(1, 16'h0100, 16'hFF00);
      chk({31'h0, avg_valid}, 32'h1, "valid at depth");
    end
    wr(`VCA_OFF_CTRL, 32'h18);
    rd(`VCA_OFF_CTRL, 32'h14, 32'h1C, 1'b0);
    chk({31'h0, avg_valid}, 32'h1, "reserved depth kept");
    print_verdict();
  end
endmodule // tb_voltage_current_result_averager
